// ---- ipet_map.vh ----
// Register indices, field positions and reset values of the input port event trigger
`ifndef IPET_MAP_VH
`define IPET_MAP_VH
`define IPET_CTRL_INDEX    8'h1B
`define IPET_FLAGS_INDEX   8'h1C
`define IPET_CTRL_ADDR     12'h06C
`define IPET_FLAGS_ADDR    12'h070
`define IPET_EN_LSB        0
`define IPET_EDGE_LSB      8
`define IPET_CTRL_WIDTH    16
`define IPET_CTRL_RESET    16'h0000
`define IPET_FLAGS_RESET   8'h00
`endif

// ---- ipet_bit_trig.v ----
// One input bit: pin synchroniser, edge detector and trigger qualifier
`timescale 1ns/100ps
module ipet_bit_trig
(
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Pin and settings
    input  wire pin,
    input  wire enable,
    input  wire rising,
    input  wire flag,
    // Trigger pulse
    output wire trig
);
    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg level_reg;
    reg level_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser, level accepted when second and third stages agree
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg      <= 1'b0;
            sync2_reg      <= 1'b0;
            sync3_reg      <= 1'b0;
            level_reg      <= 1'b0;
            level_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg      <= pin;
            sync2_reg      <= sync1_reg;
            sync3_reg      <= sync2_reg;
            if (sync2_reg == sync3_reg)
                level_reg  <= sync3_reg;
            level_prev_reg <= level_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge select, enable and suppression while latched
    wire rise_edge = level_reg & ~level_prev_reg;
    wire fall_edge = ~level_reg & level_prev_reg;

    assign trig = enable & ~flag & (rising ? rise_edge : fall_edge);
endmodule

// ---- ipet_top.v ----
// Input port event trigger with APB register access
//
// Summary of operation
// - Control bits 7..0 enable detection per input bit; disabled bits never trigger.
// - Control bits 15..8 pick rising (1) or falling (0) edge per bit.
// - Combined trigger output is the OR of all eight bit triggers.
// - Detection uses real pin levels, never indicator outputs.
// - Flag bit reads 1 after a trigger on its bit, else 0.
// - A latched flag blocks further triggers from its bit until cleared.
// - Software clears a flag by writing 0 then 1 to it.
// - In FIFO mode flags clear automatically once the trigger is handled.
`timescale 1ns/100ps
`include "ipet_map.vh"
module ipet_top
#(
    parameter NBITS = 8
)
(
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output wire             pready,
    output wire             pslverr,
    output wire [31:0]      prdata,
    // Input port connector pins
    input  wire [NBITS-1:0] input_port_connector,
    // FIFO handling of triggers
    input  wire             fifo_in_use,
    input  wire             trig_handled,
    // Combined trigger
    output wire             combined_trig_out
);
    reg  [`IPET_CTRL_WIDTH-1:0] ctrl_reg;
    reg  [`IPET_CTRL_WIDTH-1:0] ctrl_next;
    reg  [NBITS-1:0]            flags_reg;
    reg  [NBITS-1:0]            flags_next;
    reg  [NBITS-1:0]            armed_reg;
    reg  [NBITS-1:0]            armed_next;
    reg  [NBITS-1:0]            soft_clear;
    reg  [NBITS-1:0]            auto_clear;
    reg  [31:0]                 rdata_reg;
    reg  [31:0]                 rdata_next;
    reg                         comb_reg;
    reg                         hit_ctrl;
    reg                         hit_flags;
    wire [NBITS-1:0]            bit_trig;
    wire [NBITS-1:0]            en_bits;
    wire [NBITS-1:0]            edge_bits;
    wire [NBITS-1:0]            wr_bits;
    wire                        access;
    wire                        rd_setup;
    wire                        wr_ctrl;
    wire                        wr_flags;
    wire                        any_trig;

    ////////////////////////////////////////////////////////////////////////
    // APB address decode
    always @*
    begin
        hit_ctrl  = 1'b0;
        hit_flags = 1'b0;
        case (paddr)
            `IPET_CTRL_ADDR:
            begin
                hit_ctrl = 1'b1;
            end
            `IPET_FLAGS_ADDR:
            begin
                hit_flags = 1'b1;
            end
            default:
            begin
                hit_ctrl  = 1'b0;
                hit_flags = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB strobes and responses
    assign access   = psel & penable;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_ctrl  = access & pwrite & hit_ctrl;
    assign wr_flags = access & pwrite & hit_flags;
    assign wr_bits  = pwdata[NBITS-1:0];

    assign pready  = 1'b1;
    assign pslverr = access & ~hit_ctrl & ~hit_flags;
    assign prdata  = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Control fields
    assign en_bits   = ctrl_reg[`IPET_EN_LSB +: NBITS];
    assign edge_bits = ctrl_reg[`IPET_EDGE_LSB +: NBITS];

    ////////////////////////////////////////////////////////////////////////
    // Per-bit detectors
    genvar i;
    generate
        for (i = 0; i < NBITS; i = i + 1)
        begin : g_bit
            ipet_bit_trig u_bit
            (
                .pclk    (pclk),
                .presetn (presetn),
                .pin     (input_port_connector[i]),
                .enable  (en_bits[i]),
                .rising  (edge_bits[i]),
                .flag    (flags_reg[i]),
                .trig    (bit_trig[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Software clear, armed bits written 1
    always @*
    begin
        soft_clear = {NBITS{1'b0}};
        if (wr_flags)
            soft_clear = armed_reg & wr_bits;
    end

    // Automatic clear once the FIFO has taken the trigger
    always @*
    begin
        auto_clear = {NBITS{1'b0}};
        if (fifo_in_use && trig_handled)
            auto_clear = {NBITS{1'b1}};
    end

    // Bits written 0 arm, bits written 1 disarm
    always @*
    begin
        armed_next = armed_reg;
        if (wr_flags)
            armed_next = ~wr_bits;
    end

    // A trigger in the clearing cycle keeps its flag
    always @*
    begin
        flags_next = flags_reg & ~(soft_clear | auto_clear);
        flags_next = flags_next | bit_trig;
    end

    // Control write
    always @*
    begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl)
            ctrl_next = pwdata[`IPET_CTRL_WIDTH-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data selection
    always @*
    begin
        rdata_next = 32'h00000000;
        if (hit_ctrl)
            rdata_next = {{(32-`IPET_CTRL_WIDTH){1'b0}}, ctrl_reg};
        else if (hit_flags)
            rdata_next = {{(32-NBITS){1'b0}}, flags_reg};
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `IPET_CTRL_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag register
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_reg <= `IPET_FLAGS_RESET;
        else
            flags_reg <= flags_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear-sequence arming
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_reg <= {NBITS{1'b0}};
        else
            armed_reg <= armed_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, loaded in the setup cycle of a read
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_reg <= 32'h00000000;
        else if (rd_setup)
            rdata_reg <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Combined trigger
    assign any_trig = |bit_trig;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            comb_reg <= 1'b0;
        else
            comb_reg <= any_trig;
    end

    assign combined_trig_out = comb_reg;
endmodule

// ---- ipet_pin_model.sv ----
// External pins on the input port connector
`timescale 1ns/100ps
module ipet_pin_model
(
    input  wire       pclk,
    input  wire [7:0] level,
    output reg  [7:0] pins
);
    initial pins = 8'h00;
    always @(posedge pclk) pins <= level;
endmodule

// ---- ipet_top_asserts.sv ----
// Port checker for the input port event trigger
`timescale 1ns/100ps
module ipet_top_asserts
#(
    parameter NBITS = 8
)
(
    input wire             pclk,
    input wire             presetn,
    input wire             psel,
    input wire             penable,
    input wire             pwrite,
    input wire [11:0]      paddr,
    input wire [31:0]      pwdata,
    input wire             pready,
    input wire             pslverr,
    input wire [31:0]      prdata,
    input wire [NBITS-1:0] input_port_connector,
    input wire             combined_trig_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg  [15:0]      ctl;
    reg  [NBITS-1:0] pv;
    reg  [3:0]       q;
    wire             acc = psel && penable;
    wire             map = paddr == 12'h06C || paddr == 12'h070;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ctl <= 16'h0000;
            pv <= {NBITS{1'b0}};
            q <= 4'hF;
        end
        else
        begin
            if (acc && pwrite && paddr == 12'h06C)
                ctl <= pwdata[15:0];
            pv <= input_port_connector;
            q <= (input_port_connector != pv) ? 4'h0 : (q == 4'hF) ? q : q + 4'h1;
        end
    property p_en; combined_trig_out |-> ctl[7:0] != 8'h00; endproperty
    a_en: assert property (p_en) else $error("trigger while disabled");
    property p_lat; combined_trig_out |-> q >= 4'h1 && q <= 4'h8; endproperty
    a_lat: assert property (p_lat) else $error("trigger without pin edge");
    property p_one; combined_trig_out |=> !combined_trig_out; endproperty
    a_one: assert property (p_one) else $error("trigger too long");
    property p_crd; acc && !pwrite && paddr == 12'h06C |-> prdata == {16'h0000, ctl}; endproperty
    a_crd: assert property (p_crd) else $error("control readback");
    property p_frd; acc && !pwrite && paddr == 12'h070 |-> prdata[31:8] == 24'h000000; endproperty
    a_frd: assert property (p_frd) else $error("flags upper bits");
    property p_err; acc && !map |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped");
    property p_ok; acc && map |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on mapped");
    property p_rdy; psel |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state");
endmodule
bind ipet_top ipet_top_asserts #(.NBITS(NBITS)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .input_port_connector(input_port_connector), .combined_trig_out(combined_trig_out));

// ---- ipet_top_tb.sv ----
// Testbench for the input port event trigger
`timescale 1ns/100ps
module ipet_top_tb;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fifo = 0, hand = 0, err = 0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [7:0]  level = 8'h00;
    wire        pready, pslverr, cto;
    wire [31:0] prdata;
    wire [7:0]  pins;
    integer     bad_count = 0, total_checks = 0, nt = 0, i;
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (cto === 1'b1) nt = nt + 1;
    ipet_pin_model i_pins (.pclk(pclk), .level(level), .pins(pins));
    ipet_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .input_port_connector(pins), .fifo_in_use(fifo), .trig_handled(hand), .combined_trig_out(cto));
    task check(input [31:0] g, input [31:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("mismatch %0t %h %h", $time, g, e);
        end
    end
    endtask
    task results;
    begin
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin @(posedge pclk); i = i + 1; end while (pready !== 1'b1 && i < 8);
        err = pslverr;
        if (pready !== 1'b1)
        begin
            bad_count = bad_count + 1;
            results;
        end
        else
            {psel, penable} <= 2'b00;
    end
    endtask
    task rd(input [11:0] a, input [31:0] e);
    begin
        apb(0, a, 32'h0);
        check(prdata, e);
    end
    endtask
    task pin(input [7:0] v, input [31:0] n);
    begin
        @(posedge pclk);
        level <= v;
        repeat (10) @(posedge pclk);
        check(nt, n);
    end
    endtask
    task handle(input f, input [31:0] e);
    begin
        @(posedge pclk);
        {fifo, hand} <= {f, 1'b1};
        @(posedge pclk);
        hand <= 0;
        rd(12'h070, e);
    end
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        rd(12'h06C, 32'h0);
        rd(12'h070, 32'h0);
        apb(1, 12'h074, 32'hFFFF);
        check(err, 1);
        rd(12'h074, 32'h0);
        apb(1, 12'h06C, 32'hFFFF030F);
        check(err, 0);
        rd(12'h06C, 32'h030F);
        $display("test registers done");
        pin(8'hFF, 1);
        pin(8'h00, 2);
        pin(8'hFF, 2);
        rd(12'h070, 32'h0F);
        $display("test edges done");
        apb(1, 12'h070, 32'hFF);
        rd(12'h070, 32'h0F);
        apb(1, 12'h070, 32'h00);
        apb(1, 12'h070, 32'h01);
        rd(12'h070, 32'h0E);
        pin(8'h00, 2);
        pin(8'hFF, 3);
        $display("test clear done");
        handle(0, 32'h0F);
        handle(1, 32'h0);
        pin(8'h00, 4);
        $display("test fifo done");
        results;
    end
endmodule
